//--- pkg/bram_pkg.sv
package bram_pkg;
  // array geometry
  localparam int DW          = 36;
  localparam int AW          = 14;
  localparam int MEM_BITS    = 18432;
  localparam int NARROW_BITS = 16384;
  localparam int BASE_W      = 20;
  // apb register map
  localparam int              PAW           = 12;
  localparam logic [PAW-1:0]  CTRL_OFF      = 12'h000;
  localparam logic [PAW-1:0]  PORTA_CFG_OFF = 12'h004;
  localparam logic [PAW-1:0]  PORTB_CFG_OFF = 12'h008;
  localparam logic [PAW-1:0]  INIT_ADDR_OFF = 12'h00c;
  localparam logic [PAW-1:0]  INIT_DATA_OFF = 12'h010;
  localparam logic [PAW-1:0]  STATUS_OFF    = 12'h014;
  // field positions
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_USER_EN_BIT = 2;
  localparam int CTRL_ROM_BIT     = 3;
  localparam int PCFG_WIDTH_LSB   = 0;
  localparam int PCFG_WMODE_LSB   = 3;
  localparam int PCFG_OREG_BIT    = 5;
  localparam int PCFG_ASYNC_BIT   = 6;
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [6:0] PCFG_RST = 7'h00;
  // preload lanes are nine bits wide
  localparam int INIT_W  = 9;
  localparam int INIT_AW = 11;

  typedef enum logic [1:0] {
    MODE_SINGLE, MODE_TRUE_DUAL, MODE_PSEUDO_DUAL
  } mem_mode_t;
  typedef enum logic [2:0] {
    W_X1, W_X2, W_X4, W_X9, W_X18, W_X36
  } width_t;
  typedef enum logic [1:0] {
    WR_NORMAL, WR_THROUGH, WR_READ_FIRST
  } wr_mode_t;

  // number of data bits for a width code
  function automatic logic [5:0] width_bits(width_t w);
    unique case (w)
      W_X1:    return 6'h01;
      W_X2:    return 6'h02;
      W_X4:    return 6'h04;
      W_X9:    return 6'h09;
      W_X18:   return 6'h12;
      W_X36:   return 6'h24;
      default: return 6'h00;
    endcase
  endfunction
endpackage

//--- pkg/cfg_if.sv
`timescale 1ns/100ps
interface cfg_if;
  import bram_pkg::*;
  mem_mode_t             mode;
  logic                  user_en;
  logic                  rom_lock;
  width_t                width [2];
  wr_mode_t              wmode [2];
  logic                  oreg_en [2];
  logic                  async_rst [2];
  logic                  init_we;
  logic [INIT_AW-1:0]    init_addr;
  logic [INIT_W-1:0]     init_data;
  logic [1:0]            cfg_err;
  modport regs (output mode, user_en, rom_lock, width, wmode, oreg_en,
                async_rst, init_we, init_addr, init_data, input cfg_err);
  modport core (input mode, user_en, rom_lock, width, wmode, oreg_en,
                async_rst, init_we, init_addr, init_data, output cfg_err);
endinterface

//--- design/port_out_stage.sv
`timescale 1ns/100ps
module port_out_stage (
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // core latch load
  input  wire logic                    ld_in,
  input  wire logic [bram_pkg::DW-1:0] ld_data_in,
  // configuration and clear
  input  wire logic                    oreg_en_in,
  input  wire logic                    async_rst_in,
  input  wire logic                    clr_in,
  // read data
  output logic      [bram_pkg::DW-1:0] dout_out
);
  import bram_pkg::*;
  logic [DW-1:0] latch_r;
  logic [DW-1:0] oreg_r;

  // output latch of the core, cleared by local or global reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || clr_in) begin
      latch_r <= '0;
    end else if (ld_in) begin
      latch_r <= ld_data_in;
    end
  end

  // optional pipeline register adds one cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || clr_in) begin
      oreg_r <= '0;
    end else begin
      oreg_r <= latch_r;
    end
  end

  // asynchronous mode masks the output while clear is high
  always_comb begin
    if (async_rst_in && clr_in) begin
      dout_out = '0;
    end else begin
      dout_out = oreg_en_in ? oreg_r : latch_r;
    end
  end

  sequence sq_load_pipe;
    ld_in && !clr_in ##1 oreg_en_in && !clr_in;
  endsequence
  a_oreg_extra_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sq_load_pipe |=> (!oreg_en_in || clr_in ||
                      dout_out == $past(ld_data_in, 2)))
    else $error("output register latency wrong");
  a_clear_latches: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clr_in |=> latch_r == '0 && oreg_r == '0)
    else $error("output latches not cleared");
  a_async_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    async_rst_in && clr_in |-> dout_out == '0)
    else $error("async clear did not mask output");
endmodule

//--- design/cfg_regs.sv
`timescale 1ns/100ps
module cfg_regs (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // apb slave
  input  wire logic [bram_pkg::PAW-1:0] paddr_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  // configuration to the core
  cfg_if.regs                           cfg_io
);
  import bram_pkg::*;
  logic [3:0]         ctrl_r;
  logic [6:0]         pcfg_r [2];
  logic [INIT_AW-1:0] init_addr_r;
  logic [INIT_AW-1:0] init_wa_r;
  logic [INIT_W-1:0]  init_data_r;
  logic               init_we_r;
  logic [31:0]        prdata_r;
  logic [31:0]        rd_nxt;
  logic               hit;
  logic               wr_acc;

  assign wr_acc      = psel_in && penable_in && pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit;
  assign prdata_out  = prdata_r;

  // address decode and read mux
  always_comb begin
    hit    = 1'b1;
    rd_nxt = 32'h0;
    case (paddr_in)
      CTRL_OFF:      rd_nxt = {28'h0, ctrl_r};
      PORTA_CFG_OFF: rd_nxt = {25'h0, pcfg_r[0]};
      PORTB_CFG_OFF: rd_nxt = {25'h0, pcfg_r[1]};
      INIT_ADDR_OFF: rd_nxt = {21'h0, init_addr_r};
      INIT_DATA_OFF: rd_nxt = 32'h0;
      STATUS_OFF:    rd_nxt = {30'h0, cfg_io.cfg_err};
      default:       hit    = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_r <= 32'h0;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_r <= rd_nxt;
    end
  end

  // control and per-port configuration
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_r    <= CTRL_RST;
      pcfg_r[0] <= PCFG_RST;
      pcfg_r[1] <= PCFG_RST;
    end else if (wr_acc) begin
      if (paddr_in == CTRL_OFF) ctrl_r <= pwdata_in[3:0];
      if (paddr_in == PORTA_CFG_OFF) pcfg_r[0] <= pwdata_in[6:0];
      if (paddr_in == PORTB_CFG_OFF) pcfg_r[1] <= pwdata_in[6:0];
    end
  end

  // preload writes, only before user operation starts
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      init_addr_r <= '0;
      init_wa_r   <= '0;
      init_data_r <= '0;
      init_we_r   <= 1'b0;
    end else begin
      init_we_r <= 1'b0;
      if (wr_acc && paddr_in == INIT_ADDR_OFF) begin
        init_addr_r <= pwdata_in[INIT_AW-1:0];
      end else if (wr_acc && paddr_in == INIT_DATA_OFF &&
                   !ctrl_r[CTRL_USER_EN_BIT]) begin
        init_we_r   <= 1'b1;
        init_wa_r   <= init_addr_r;
        init_data_r <= pwdata_in[INIT_W-1:0];
        init_addr_r <= init_addr_r + 1'b1;
      end
    end
  end

  // drive the configuration bundle
  assign cfg_io.mode      = mem_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign cfg_io.user_en   = ctrl_r[CTRL_USER_EN_BIT];
  assign cfg_io.rom_lock  = ctrl_r[CTRL_ROM_BIT];
  assign cfg_io.init_we   = init_we_r;
  assign cfg_io.init_addr = init_wa_r;
  assign cfg_io.init_data = init_data_r;
  for (genvar gp = 0; gp < 2; gp++) begin : g_pcfg
    assign cfg_io.width[gp]     = width_t'(pcfg_r[gp][PCFG_WIDTH_LSB +: 3]);
    assign cfg_io.wmode[gp]     = wr_mode_t'(pcfg_r[gp][PCFG_WMODE_LSB +: 2]);
    assign cfg_io.oreg_en[gp]   = pcfg_r[gp][PCFG_OREG_BIT];
    assign cfg_io.async_rst[gp] = pcfg_r[gp][PCFG_ASYNC_BIT];
  end
endmodule

//--- design/block_ram_dual_port.sv
//
// Overview of operation
// - each port takes its own data width in every multi-port mode
// - bits map word 0 LSB..MSB, then word 1, same for every width
// - array accepts preloaded contents before user operation starts
// - preloaded array with writes locked acts as read-only memory
// - address and write data are registered before reaching the array
// - optional output register adds one cycle of read latency
// - normal mode: output changes only on reads, never on writes
// - write-through mode: written data appears on the same port output
// - read-before-write shows old contents; only x9, x18, x36 widths
// - output latches clear synchronously or asynchronously by choice
// - each port's local reset clears only its own output latches
// - active-low global reset clears both ports' output latches
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
module block_ram_dual_port (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // apb register bus
  input  wire logic [bram_pkg::PAW-1:0] paddr_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  // device-wide reset pin
  input  wire logic                     global_set_reset_n_in,
  // first port
  input  wire logic                     port_a_clk_en_in,
  input  wire logic                     port_a_we_in,
  input  wire logic [bram_pkg::AW-1:0]  port_a_addr_in,
  input  wire logic [bram_pkg::DW-1:0]  port_a_din_in,
  input  wire logic                     first_port_output_reset_in,
  output logic      [bram_pkg::DW-1:0]  port_a_dout_out,
  // second port
  input  wire logic                     port_b_clk_en_in,
  input  wire logic                     port_b_we_in,
  input  wire logic [bram_pkg::AW-1:0]  port_b_addr_in,
  input  wire logic [bram_pkg::DW-1:0]  port_b_din_in,
  input  wire logic                     second_port_output_reset_in,
  output logic      [bram_pkg::DW-1:0]  port_b_dout_out
);
  import bram_pkg::*;

  cfg_if cfg ();

  logic [MEM_BITS-1:0] mem_r;
  logic                gsr_meta_r;
  logic                gsr_sync_r;
  logic                global_clr;
  logic                ce_i [2];
  logic                we_i [2];
  logic [AW-1:0]       addr_i [2];
  logic [DW-1:0]       din_i [2];
  logic                lrst_i [2];
  logic [DW-1:0]       dout_o [2];
  logic                ce_r [2];
  logic                we_r [2];
  logic [AW-1:0]       addr_r [2];
  logic [DW-1:0]       din_r [2];
  logic [5:0]          wbits [2];
  logic [DW-1:0]       mask [2];
  logic [BASE_W-1:0]   base [2];
  logic                in_range [2];
  logic                shape_bad [2];
  logic                rbw_bad [2];
  logic                may_wr [2];
  logic                may_rd [2];
  logic                en [2];
  logic                wr [2];
  logic                rd [2];
  logic                ld [2];
  logic                clr [2];
  logic [DW-1:0]       rd_word [2];
  logic [DW-1:0]       ld_data [2];
  wr_mode_t            eff [2];
  logic                err [2];
  logic                plain_a;
  logic                plain_b;

  // apb register file
  cfg_regs u_regs (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .paddr_in    (paddr_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .cfg_io      (cfg)
  );

  // gather port pins into per-port arrays
  assign ce_i[0]         = port_a_clk_en_in;
  assign ce_i[1]         = port_b_clk_en_in;
  assign we_i[0]         = port_a_we_in;
  assign we_i[1]         = port_b_we_in;
  assign addr_i[0]       = port_a_addr_in;
  assign addr_i[1]       = port_b_addr_in;
  assign din_i[0]        = port_a_din_in;
  assign din_i[1]        = port_b_din_in;
  assign lrst_i[0]       = first_port_output_reset_in;
  assign lrst_i[1]       = second_port_output_reset_in;
  assign port_a_dout_out = dout_o[0];
  assign port_b_dout_out = dout_o[1];
  assign cfg.cfg_err     = {err[1], err[0]};

  // global reset pin passes two flip-flops
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gsr_meta_r <= 1'b1;
      gsr_sync_r <= 1'b1;
    end else begin
      gsr_meta_r <= global_set_reset_n_in;
      gsr_sync_r <= gsr_meta_r;
    end
  end
  assign global_clr = !gsr_sync_r;

  for (genvar gp = 0; gp < 2; gp++) begin : g_port
    // input registers in front of the array
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        ce_r[gp]   <= 1'b0;
        we_r[gp]   <= 1'b0;
        addr_r[gp] <= '0;
        din_r[gp]  <= '0;
      end else begin
        ce_r[gp]   <= ce_i[gp];
        we_r[gp]   <= we_i[gp];
        addr_r[gp] <= addr_i[gp];
        din_r[gp]  <= din_i[gp];
      end
    end

    // width, bit offset and range of the addressed word
    always_comb begin
      logic [DW:0] m;
      int          cap;
      m            = '0;
      cap          = 0;
      wbits[gp]    = width_bits(cfg.width[gp]);
      m            = ({{DW{1'b0}}, 1'b1} << wbits[gp]) - 1'b1;
      mask[gp]     = m[DW-1:0];
      base[gp]     = BASE_W'(addr_r[gp]) * BASE_W'(wbits[gp]);
      cap          = (wbits[gp] >= 6'h09) ? MEM_BITS : NARROW_BITS;
      in_range[gp] = (int'(base[gp]) + int'(wbits[gp])) <= cap;
    end

    // port roles per memory mode
    always_comb begin
      shape_bad[gp] = (wbits[gp] == 6'h00);
      unique case (cfg.mode)
        MODE_SINGLE: begin
          may_wr[gp] = (gp == 0);
          may_rd[gp] = (gp == 0);
        end
        MODE_TRUE_DUAL: begin
          may_wr[gp]    = 1'b1;
          may_rd[gp]    = 1'b1;
          shape_bad[gp] = shape_bad[gp] || cfg.width[gp] == W_X36;
        end
        MODE_PSEUDO_DUAL: begin
          may_wr[gp] = (gp == 0);
          may_rd[gp] = (gp == 1);
        end
        default: begin
          may_wr[gp]    = 1'b0;
          may_rd[gp]    = 1'b0;
          shape_bad[gp] = 1'b1;
        end
      endcase
    end

    // read-before-write falls back to normal on narrow widths
    always_comb begin
      rbw_bad[gp] = cfg.wmode[gp] == WR_READ_FIRST &&
                    wbits[gp] < 6'h09;
      if (rbw_bad[gp] || cfg.wmode[gp] > WR_READ_FIRST) begin
        eff[gp] = WR_NORMAL;
      end else begin
        eff[gp] = cfg.wmode[gp];
      end
    end

    assign err[gp] = shape_bad[gp] || rbw_bad[gp];
    assign en[gp]  = cfg.user_en && ce_r[gp] && !shape_bad[gp] &&
                     in_range[gp];
    assign wr[gp]  = en[gp] && we_r[gp] && may_wr[gp] &&
                     !cfg.rom_lock;
    assign rd[gp]  = en[gp] && !we_r[gp] && may_rd[gp];
    assign clr[gp] = lrst_i[gp] || global_clr;

    // current contents of the addressed word
    always_comb begin
      for (int i = 0; i < DW; i++) begin
        if (i < int'(wbits[gp]) && int'(base[gp]) + i < MEM_BITS) begin
          rd_word[gp][i] = mem_r[int'(base[gp]) + i];
        end else begin
          rd_word[gp][i] = 1'b0;
        end
      end
    end

    // what the output latch takes per write behaviour
    always_comb begin
      ld_data[gp] = rd_word[gp];
      unique case (eff[gp])
        WR_NORMAL: begin
          ld[gp] = rd[gp];
        end
        WR_THROUGH: begin
          ld[gp] = rd[gp] || wr[gp];
          if (wr[gp]) ld_data[gp] = din_r[gp] & mask[gp];
        end
        WR_READ_FIRST: begin
          ld[gp] = rd[gp] || wr[gp];
        end
      endcase
    end

    port_out_stage u_out (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .ld_in        (ld[gp]),
      .ld_data_in   (ld_data[gp]),
      .oreg_en_in   (cfg.oreg_en[gp]),
      .async_rst_in (cfg.async_rst[gp]),
      .clr_in       (clr[gp]),
      .dout_out     (dout_o[gp])
    );
  end

  // storage array: preload lanes, then port writes, second port last
  always_ff @(posedge clk_in) begin
    if (cfg.init_we) begin
      for (int i = 0; i < INIT_W; i++) begin
        mem_r[int'(cfg.init_addr) * INIT_W + i] <= cfg.init_data[i];
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < DW; i++) begin
        if (wr[p] && i < int'(wbits[p]) &&
            int'(base[p]) + i < MEM_BITS) begin
          mem_r[int'(base[p]) + i] <= din_r[p][i];
        end
      end
    end
  end

  // checks on the first port and the shared array, plus second-port x36 refusal and global reset of both outputs
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  assign plain_a = !cfg.oreg_en[0] && !clr[0];

  sequence sq_wr_a(wr_mode_t m);
    wr[0] && eff[0] == m && plain_a ##1 plain_a;
  endsequence
  sequence sq_rd_a;
    rd[0] && plain_a ##1 plain_a;
  endsequence

  a_input_capture: assert property (
    port_a_clk_en_in |=> ce_r[0] && addr_r[0] == $past(port_a_addr_in) &&
                         din_r[0] == $past(port_a_din_in))
    else $error("port inputs not registered");
  a_read_latency: assert property (
    sq_rd_a |-> port_a_dout_out == $past(rd_word[0]))
    else $error("read data not on output next cycle");
  a_normal_hold: assert property (
    sq_wr_a(WR_NORMAL) |-> $stable(port_a_dout_out))
    else $error("normal write changed the output");
  a_through_echo: assert property (
    sq_wr_a(WR_THROUGH) |-> port_a_dout_out == $past(din_r[0] & mask[0]))
    else $error("write-through data missing on output");
  a_read_first_old: assert property (
    sq_wr_a(WR_READ_FIRST) |-> port_a_dout_out == $past(rd_word[0]))
    else $error("old contents missing on read-before-write");
  a_rbw_narrow_err: assert property (
    cfg.wmode[0] == WR_READ_FIRST && wbits[0] < 6'h09 |->
      cfg.cfg_err[0] && eff[0] == WR_NORMAL)
    else $error("narrow read-before-write not refused");
  a_tdp_no_x36: assert property (
    cfg.mode == MODE_TRUE_DUAL && cfg.width[1] == W_X36 |->
      !wr[1] && !rd[1] && cfg.cfg_err[1])
    else $error("x36 used in true dual-port mode");
  a_rom_frozen: assert property (
    cfg.rom_lock && !cfg.init_we |=> $stable(mem_r))
    else $error("array changed while write-locked");
  a_local_reset: assert property (
    first_port_output_reset_in |=> port_a_dout_out == '0)
    else $error("first port local reset ignored");
  a_global_reset: assert property (
    !gsr_sync_r |=> port_a_dout_out == '0 && port_b_dout_out == '0)
    else $error("global reset did not clear outputs");

  // checks on the second port and on isolation between ports
  assign plain_b = !cfg.oreg_en[1] && !clr[1];

  sequence sq_rd_b;
    rd[1] && plain_b ##1 plain_b;
  endsequence
  sequence sq_rbw_b;
    wr[1] && eff[1] == WR_READ_FIRST && plain_b ##1 plain_b;
  endsequence

  a_b_input_capture: assert property (
    port_b_clk_en_in |=> ce_r[1] && addr_r[1] == $past(port_b_addr_in) &&
                         din_r[1] == $past(port_b_din_in))
    else $error("second port inputs not registered");
  a_b_read_latency: assert property (
    sq_rd_b |-> port_b_dout_out == $past(rd_word[1]))
    else $error("second port read data late");
  a_b_read_first_old: assert property (
    sq_rbw_b |-> port_b_dout_out == $past(rd_word[1]))
    else $error("second port old contents missing");
  a_local_isolate: assert property (
    first_port_output_reset_in && plain_b && !ld[1] ##1 plain_b |->
      $stable(port_b_dout_out))
    else $error("first port reset disturbed second port");

  // port roles per memory mode and write lock
  a_pseudo_roles: assert property (
    cfg.mode == MODE_PSEUDO_DUAL |-> !wr[1] && !rd[0])
    else $error("pseudo dual-port roles not kept");
  a_single_roles: assert property (
    cfg.mode == MODE_SINGLE |-> !wr[1] && !rd[1])
    else $error("second port active in single-port mode");
  a_dual_write: assert property (
    wr[0] && wr[1] |-> cfg.mode == MODE_TRUE_DUAL)
    else $error("both ports wrote outside true dual-port mode");
  a_rom_no_write: assert property (
    cfg.rom_lock |-> !wr[0] && !wr[1])
    else $error("port write while write-locked");
endmodule

//--- dv/port_drv.sv
`timescale 1ns/100ps
// user fabric model driving one memory port
module port_drv (
  // clock
  input  wire logic                    clk_in,
  // port request
  output logic                         clk_en_out,
  output logic                         we_out,
  output logic      [bram_pkg::AW-1:0] addr_out,
  output logic      [bram_pkg::DW-1:0] din_out
);
  import bram_pkg::*;
  // idle lines at time zero
  initial begin
    clk_en_out = 1'b0;
    we_out     = 1'b0;
    addr_out   = '0;
    din_out    = '0;
  end
  // one request cycle, then lines show inverted stale values
  task automatic req(input logic we, input logic [AW-1:0] a,
                     input logic [DW-1:0] d);
    @(posedge clk_in);
    clk_en_out <= 1'b1;
    we_out     <= we;
    addr_out   <= a;
    din_out    <= d;
    @(posedge clk_in);
    clk_en_out <= 1'b0;
    we_out     <= ~we;
    addr_out   <= ~a;
    din_out    <= ~d;
  endtask
endmodule

//--- dv/block_ram_dual_port_tb.sv
`timescale 1ns/100ps
module block_ram_dual_port_tb;
  import bram_pkg::*;
  localparam logic [DW-1:0] M9  = 36'h1ff;
  localparam logic [DW-1:0] M18 = 36'h3ffff;
  logic           clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic           gsr_n, lra, lrb, a_en, a_we, b_en, b_we, e;
  logic [PAW-1:0] paddr;
  logic [31:0]    pwdata, prdata, q;
  logic [AW-1:0]  a_ad, b_ad;
  logic [DW-1:0]  a_di, b_di, a_do, b_do;
  logic [8:0]     ln [4];
  int             n_mismatch, check_count;

  // fabric side of each port
  port_drv pa (.clk_in(clk_in), .clk_en_out(a_en), .we_out(a_we),
               .addr_out(a_ad), .din_out(a_di));
  port_drv pb (.clk_in(clk_in), .clk_en_out(b_en), .we_out(b_we),
               .addr_out(b_ad), .din_out(b_di));
  block_ram_dual_port block_ram_dual_port_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .global_set_reset_n_in(gsr_n),
    .port_a_clk_en_in(a_en), .port_a_we_in(a_we), .port_a_addr_in(a_ad),
    .port_a_din_in(a_di), .first_port_output_reset_in(lra),
    .port_a_dout_out(a_do), .port_b_clk_en_in(b_en), .port_b_we_in(b_we),
    .port_b_addr_in(b_ad), .port_b_din_in(b_di),
    .second_port_output_reset_in(lrb), .port_b_dout_out(b_do));

  // free running clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DW-1:0] exp,
                     input logic [DW-1:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [PAW-1:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic rd(input string nm, input logic [PAW-1:0] a,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, {4'h0, exp}, {4'h0, q});
  endtask

  // port request, then compare masked output lat edges after it
  task automatic op(input string nm, input bit p, input logic we,
                    input logic [AW-1:0] a, input logic [DW-1:0] d,
                    input int lat, input logic [DW-1:0] m,
                    input logic [DW-1:0] exp);
    if (p) pb.req(we, a, d);
    else pa.req(we, a, d);
    repeat (lat - 1) @(posedge clk_in);
    #1;
    chk(nm, exp, (p ? b_do : a_do) & m);
  endtask

  // main sequence
  initial begin
    rst_n_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    gsr_n = 1'b1;
    lra = 1'b0;
    lrb = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    ln = '{9'h1a5, 9'h05a, 9'h0c3, 9'h13c};
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd("ctrl", CTRL_OFF, 32'h0);
    rd("cfg a", PORTA_CFG_OFF, 32'h0);
    rd("cfg b", PORTB_CFG_OFF, 32'h0);
    rd("status", STATUS_OFF, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk("slverr", 36'h1, {35'h0, e});
    $display("test registers done");
    wr_init();
    op("a rom rd", 0, 0, 0, 0, 2, M9, {27'h0, ln[0]});
    op("b x18 rd", 1, 0, 0, 0, 2, M18, {18'h0, ln[1], ln[0]});
    op("a rom wr", 0, 1, 0, 36'h0ff, 2, M9, {27'h0, ln[0]});
    apb(1'b1, CTRL_OFF, 32'h5);
    op("a rom kept", 0, 0, 0, 0, 2, M9, {27'h0, ln[0]});
    op("a normal wr", 0, 1, 2, 36'h0ff, 2, M9, {27'h0, ln[0]});
    op("b x18 rd1", 1, 0, 1, 0, 2, M18, {18'h0, ln[3], 9'h0ff});
    apb(1'b1, PORTA_CFG_OFF, 32'h0b);
    op("a through", 0, 1, 3, 36'h011, 2, M9, 36'h011);
    apb(1'b1, PORTA_CFG_OFF, 32'h13);
    op("a rbw", 0, 1, 3, 36'h022, 2, M9, 36'h011);
    apb(1'b1, PORTA_CFG_OFF, 32'h23);
    op("a oreg", 0, 0, 3, 0, 3, M9, 36'h022);
    $display("test write modes done");
    apb(1'b1, PORTA_CFG_OFF, 32'h12);
    rd("rbw x4", STATUS_OFF, 32'h1);
    apb(1'b1, PORTB_CFG_OFF, 32'h5);
    rd("x36 dual", STATUS_OFF, 32'h3);
    apb(1'b1, PORTA_CFG_OFF, 32'h3);
    apb(1'b1, PORTB_CFG_OFF, 32'h4);
    rd("shapes ok", STATUS_OFF, 32'h0);
    $display("test shapes done");
    apb(1'b1, PORTB_CFG_OFF, 32'h14);
    fork
      pa.req(1'b1, 0, {27'h0, ln[0]});
      pb.req(1'b1, 1, 36'h2468a);
    join
    @(posedge clk_in);
    #1;
    chk("a dual hold", 36'h022, a_do & M9);
    chk("b dual rbw", {18'h0, 9'h022, 9'h0ff}, b_do & M18);
    op("b dual rd", 1, 0, 1, 0, 2, M18, 36'h2468a);
    apb(1'b1, CTRL_OFF, 32'h6);
    op("b pseudo wr", 1, 1, 0, 36'h0, 2, M18, 36'h2468a);
    apb(1'b1, CTRL_OFF, 32'h5);
    $display("test dual ports done");
    op("a pre clr", 0, 0, 0, 0, 2, M9, {27'h0, ln[0]});
    op("b pre clr", 1, 0, 0, 0, 2, M18, {18'h0, ln[1], ln[0]});
    @(posedge clk_in);
    lra <= 1'b1;
    @(posedge clk_in);
    lra <= 1'b0;
    #1;
    chk("a local clr", 36'h0, a_do);
    chk("b kept", {18'h0, ln[1], ln[0]}, b_do & M18);
    apb(1'b1, PORTA_CFG_OFF, 32'h43);
    op("a pre async", 0, 0, 0, 0, 2, M9, {27'h0, ln[0]});
    @(posedge clk_in);
    lra <= 1'b1;
    #1;
    chk("a async clr", 36'h0, a_do);
    @(posedge clk_in);
    lra <= 1'b0;
    op("a pre gsr", 0, 0, 0, 0, 2, M9, {27'h0, ln[0]});
    @(posedge clk_in);
    gsr_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk("a global clr", 36'h0, a_do);
    chk("b global clr", 36'h0, b_do);
    @(posedge clk_in);
    gsr_n <= 1'b1;
    $display("test clears done");
    summarize();
  end

  // preload four lanes, then open ports locked as rom
  task automatic wr_init();
    apb(1'b1, INIT_ADDR_OFF, 32'h0);
    for (int i = 0; i < 4; i++) apb(1'b1, INIT_DATA_OFF, {23'h0, ln[i]});
    repeat (3) @(posedge clk_in);
    apb(1'b1, PORTA_CFG_OFF, 32'h3);
    apb(1'b1, PORTB_CFG_OFF, 32'h4);
    apb(1'b1, CTRL_OFF, 32'hd);
  endtask
endmodule
